// [verilog/rs_pkg.sv]
/*
 Shared constants for the rate sensor serial link: byte addresses,
 command fields, reset values, timing counts and host register map.
 Assumes a 250 MHz pclk on both ends.
*/
package rs_pkg;
    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ      = 250;
    localparam int BACKUP_MS    = 72;
    localparam int BACKUP_CYC   = BACKUP_MS * CLK_MHZ * 1000;
    localparam int TICK_HZ      = 32768;
    localparam int TICK_CYC     = CLK_MHZ * 1000000 / TICK_HZ;
    localparam int SCLK_MAX_KHZ = 2000;
    localparam int SCLK_HALF    = (CLK_MHZ * 1000 + 2 * SCLK_MAX_KHZ - 1)
                                  / (2 * SCLK_MAX_KHZ);
    localparam int DONE_PULSE   = 4;
    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int WR_BIT     = 15;
    localparam int ADDR_MSB   = 14;
    localparam int ADDR_LSB   = 8;
    localparam int GCMD_BACKUP_BIT = 3;
    // ----------------------------------------------------------------
    // Device byte addresses and reset values
    // ----------------------------------------------------------------
    localparam logic [6:0] A_TEMP    = 7'h02;
    localparam logic [6:0] A_RATE_LO = 7'h04;
    localparam logic [6:0] A_RATE_HI = 7'h06;
    localparam logic [6:0] A_CFG0_LO = 7'h08;
    localparam logic [6:0] A_CFG0_HI = 7'h0B;
    localparam logic [6:0] A_CFG1_LO = 7'h10;
    localparam logic [6:0] A_CFG1_HI = 7'h25;
    localparam logic [6:0] A_MSC     = 7'h1C;
    localparam logic [6:0] A_PRD     = 7'h1E;
    localparam logic [6:0] A_DEC     = 7'h22;
    localparam logic [6:0] A_GCMD    = 7'h28;
    localparam logic [7:0] MSC_RST   = 8'h06;
    localparam logic [7:0] PRD_RST   = 8'h1F;
    localparam int CFG_BYTES = 64;
    // ----------------------------------------------------------------
    // Host APB register map
    // ----------------------------------------------------------------
    localparam logic [7:0] H_CMD  = 8'h00;
    localparam logic [7:0] H_STAT = 8'h04;
    localparam logic [7:0] H_RX   = 8'h08;
    localparam int ST_BUSY = 0;
    localparam int ST_SMPL = 1;
endpackage

// [verilog/spi_link_if.sv]
/*
 Serial link between the rate sensor and its host: chip select,
 clock, two data lines and the sample-done pin.
 Assumes the bench joins the two ends through this interface.
*/
`timescale 1ns/1ps
interface spi_link_if;
    logic sclk;         // Serial clock, idles high
    logic cs_n;         // Chip select, active low
    logic mosi;         // Host to device data
    logic miso_o;       // Device output value
    logic miso_oe;      // Device drives miso
    logic miso;         // Resolved shared line
    logic sample_done;  // Sample-done pin

    // Released line sits high, as a pull-up would hold it
    assign miso = miso_oe ? miso_o : 1'b1;

    modport device (input sclk, input cs_n, input mosi,
                    output miso_o, output miso_oe, output sample_done);
    modport host   (output sclk, output cs_n, output mosi,
                    input miso, input sample_done);
endinterface

// [verilog/rate_sensor_dev.sv]
/*
 Device end of the rate sensor: mode 3 serial slave, output word
 pipeline, byte-wide volatile configuration with flash mirror, and
 the autonomous sample timer driving the sample-done pin.
 Assumes pclk far faster than sclk; link pins are asynchronous.
*/
`timescale 1ns/1ps
module rate_sensor_dev #(
    parameter int TICK_CYC   = rs_pkg::TICK_CYC,   // Sample tick period
    parameter int BACKUP_CYC = rs_pkg::BACKUP_CYC  // Flash backup time
) (
    input  wire logic        pclk,                  // System clock
    input  wire logic        presetn,               // Device reset
    input  wire logic        por_n,                 // Power-on, loads flash defaults
    spi_link_if.device       link,                  // Serial link pins
    input  wire logic [31:0] rate_in,               // Filter rate result
    input  wire logic [15:0] temp_in,               // Temperature result
    output logic      [4:0]  decimation_setting,    // Decimation field
    output logic      [15:0] sample_period_setting, // Sample period
    output logic             backup_busy            // Flash backup running
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0]  cfg_q [rs_pkg::CFG_BYTES];
    logic [7:0]  flash_q [rs_pkg::CFG_BYTES];
    logic [2:0]  sclk_s_q, cs_s_q;
    logic [1:0]  mosi_s_q;
    logic [4:0]  bit_q;
    logic [15:0] rx_q, tx_q, pend_q;
    logic        pend_v_q, miso_q, oe_q, restore_q;
    logic [15:0] temp_q, rate_lo_q, rate_hi_q;
    logic [31:0] tick_q, bk_q;
    logic [15:0] prd_q;
    logic [2:0]  done_q;
    logic        done_pin_q, commit;

    // Decoded word and its fields
    logic        sclk_rise, sclk_fall, cs_act, cs_fall, frame_end;
    logic [15:0] word;
    logic [6:0]  addr;
    logic        is_wr;

    function automatic logic [7:0] cfg_dflt(input int i);
        if (7'(i) == rs_pkg::A_PRD)
            return rs_pkg::PRD_RST;
        else if (7'(i) == rs_pkg::A_MSC)
            return rs_pkg::MSC_RST;
        return 8'h00;
    endfunction

    function automatic logic wr_ok(input logic [6:0] a);
        return (a >= rs_pkg::A_CFG0_LO && a <= rs_pkg::A_CFG0_HI) ||
               (a >= rs_pkg::A_CFG1_LO && a <= rs_pkg::A_CFG1_HI);
    endfunction

    // Resolution bits kept grow down from bit 15 with decimation
    function automatic logic [15:0] lo_mask(input logic [4:0] d);
        return d[4] ? 16'hFFFF : ~(16'hFFFF >> d[3:0]);
    endfunction

    // Word at an even byte address, low byte first
    function automatic logic [15:0] reg_word(input logic [6:0] a);
        logic [6:0] lo;
        lo = {a[6:1], 1'b0};
        case (lo)
            rs_pkg::A_TEMP:    return temp_q;
            rs_pkg::A_RATE_LO: return rate_lo_q;
            rs_pkg::A_RATE_HI: return rate_hi_q;
            rs_pkg::A_GCMD:    return 16'h0000;
            default: begin
                if (lo[6])
                    return 16'h0000;
                return {cfg_q[lo[5:0] | 6'h01], cfg_q[lo[5:0]]};
            end
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Idle levels match a released bus: clock and select high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_s_q <= 3'h7;
            cs_s_q   <= 3'h7;
            mosi_s_q <= 2'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], link.sclk};
            cs_s_q   <= {cs_s_q[1:0], link.cs_n};
            mosi_s_q <= {mosi_s_q[0], link.mosi};
        end
    end

    assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
    assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
    assign cs_act    = ~cs_s_q[1];
    assign cs_fall   = ~cs_s_q[1] & cs_s_q[2];
    assign word      = {rx_q[14:0], mosi_s_q[1]};
    assign frame_end = cs_act & sclk_rise
                       & (bit_q == 5'(rs_pkg::FRAME_BITS - 1));
    assign addr  = word[rs_pkg::ADDR_MSB:rs_pkg::ADDR_LSB];
    assign is_wr = word[rs_pkg::WR_BIT];

    // ----------------------------------------------------------------
    // Serial shift engine
    // ----------------------------------------------------------------
    // Answer word is captured at the request frame's end, so a new
    // sample landing mid-frame cannot tear it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_q    <= 5'h00;
            rx_q     <= 16'h0000;
            tx_q     <= 16'h0000;
            pend_q   <= 16'h0000;
            pend_v_q <= 1'b0;
            miso_q   <= 1'b0;
        end else begin
            if (cs_fall) begin
                bit_q    <= 5'h00;
                tx_q     <= pend_v_q ? pend_q : 16'h0000;
                pend_v_q <= 1'b0;
                miso_q   <= 1'b0;
            end else if (cs_act && sclk_fall) begin
                miso_q <= tx_q[15];
                tx_q   <= {tx_q[14:0], 1'b0};
            end
            if (cs_act && sclk_rise) begin
                rx_q  <= word;
                bit_q <= bit_q + 5'h01;
            end
            if (frame_end) begin
                pend_v_q <= ~is_wr;
                pend_q   <= reg_word(addr);
            end
        end
    end

    // Output enable follows the synced select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            oe_q <= 1'b0;
        else
            oe_q <= cs_act;
    end

    // ----------------------------------------------------------------
    // Volatile configuration and restore
    // ----------------------------------------------------------------
    // One cycle after release the flash image is reloaded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restore_q <= 1'b1;
            for (int i = 0; i < rs_pkg::CFG_BYTES; i++)
                cfg_q[i] <= 8'h00;
        end else if (restore_q) begin
            restore_q <= 1'b0;
            for (int i = 0; i < rs_pkg::CFG_BYTES; i++)
                cfg_q[i] <= flash_q[i];
        end else if (frame_end && is_wr && wr_ok(addr)) begin
            cfg_q[addr[5:0]] <= word[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Flash backup
    // ----------------------------------------------------------------
    // Busy ignores repeat commands; image taken at the end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            backup_busy <= 1'b0;
            bk_q        <= 32'h0000_0000;
        end else if (backup_busy) begin
            bk_q <= bk_q - 32'h0000_0001;
            if (bk_q == 32'h0000_0000)
                backup_busy <= 1'b0;
        end else if (frame_end && is_wr && addr == rs_pkg::A_GCMD
                     && word[rs_pkg::GCMD_BACKUP_BIT]) begin
            backup_busy <= 1'b1;
            bk_q        <= 32'(BACKUP_CYC - 1);
        end
    end

    assign commit = backup_busy && bk_q == 32'h0000_0000;

    // Mirror survives presetn; only power-on resets it to the cfg_dflt values
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            for (int i = 0; i < rs_pkg::CFG_BYTES; i++)
                flash_q[i] <= cfg_dflt(i);
        end else if (commit) begin
            for (int i = 0; i < rs_pkg::CFG_BYTES; i++)
                flash_q[i] <= cfg_q[i];
        end
    end

    // ----------------------------------------------------------------
    // Sample timer and output words
    // ----------------------------------------------------------------
    // Free-running from reset: no command needed to start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q    <= 32'h0000_0000;
            prd_q     <= 16'h0000;
            done_q    <= 3'h0;
            temp_q    <= 16'h0000;
            rate_lo_q <= 16'h0000;
            rate_hi_q <= 16'h0000;
        end else begin
            done_q <= (done_q != 3'h0) ? done_q - 3'h1 : 3'h0;
            if (tick_q == 32'(TICK_CYC - 1)) begin
                tick_q <= 32'h0000_0000;
                if (prd_q >= sample_period_setting) begin
                    prd_q     <= 16'h0000;
                    temp_q    <= temp_in;
                    rate_hi_q <= rate_in[31:16];
                    rate_lo_q <= rate_in[15:0] & lo_mask(decimation_setting);
                    done_q    <= 3'(rs_pkg::DONE_PULSE);
                end else begin
                    prd_q <= prd_q + 16'h0001;
                end
            end else begin
                tick_q <= tick_q + 32'h0000_0001;
            end
        end
    end

    // Pulse is stretched so a slow host can catch it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            done_pin_q <= 1'b0;
        else
            done_pin_q <= done_q != 3'h0;
    end

    assign decimation_setting    = cfg_q[rs_pkg::A_DEC[5:0]][4:0];
    assign sample_period_setting = {cfg_q[rs_pkg::A_PRD[5:0] | 6'h01],
                                    cfg_q[rs_pkg::A_PRD[5:0]]};
    assign link.miso_o      = miso_q;
    assign link.miso_oe     = oe_q;
    assign link.sample_done = done_pin_q;
endmodule

// [verilog/rate_sensor_host.sv]
/*
 Host end of the rate sensor link: APB slave with command, status
 and receive registers, and a mode 3 serial master making sclk.
 Assumes software spaces frames; the bench joins the link interface.
*/
`timescale 1ns/1ps
module rate_sensor_host (
    input  wire logic        pclk,    // System clock
    input  wire logic        presetn, // Async reset, active low
    input  wire logic [7:0]  paddr,   // APB address
    input  wire logic        psel,    // APB select
    input  wire logic        penable, // APB enable
    input  wire logic        pwrite,  // APB direction
    input  wire logic [31:0] pwdata,  // APB write data
    output logic      [31:0] prdata,  // APB read data
    output logic             pready,  // APB ready
    output logic             pslverr, // APB error
    spi_link_if.host         link     // Serial link pins
);
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_SETUP = 4'b0010,
        S_LOW   = 4'b0100,
        S_HIGH  = 4'b1000
    } state_t;

    state_t      st_q;
    logic [15:0] sh_q, rx_q, rxw_q;
    logic [7:0]  div_q;
    logic [4:0]  bit_q;
    logic        sclk_q, cs_n_q, mosi_q, seen_q;
    logic [1:0]  miso_s_q;
    logic [2:0]  done_s_q;
    logic        acc, start, half;

    // Write takes effect only at the access edge with ready high
    assign acc   = psel & penable & pready & pwrite;
    assign start = acc & paddr == rs_pkg::H_CMD & st_q == S_IDLE;
    assign half  = div_q == 8'(rs_pkg::SCLK_HALF - 1);

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // One wait-free access cycle; data prepared during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & paddr != rs_pkg::H_CMD
                       & paddr != rs_pkg::H_STAT & paddr != rs_pkg::H_RX;
            if (psel && !penable) begin
                case (paddr)
                    rs_pkg::H_STAT: prdata <= {30'h0, seen_q, st_q != S_IDLE};
                    rs_pkg::H_RX:   prdata <= {16'h0000, rxw_q};
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and sample-done flag
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miso_s_q <= 2'h0;
            done_s_q <= 3'h0;
        end else begin
            miso_s_q <= {miso_s_q[0], link.miso};
            done_s_q <= {done_s_q[1:0], link.sample_done};
        end
    end

    // Sticky; a new pulse wins over a clearing write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            seen_q <= 1'b0;
        else if (done_s_q[1] && !done_s_q[2])
            seen_q <= 1'b1;
        else if (acc && paddr == rs_pkg::H_STAT && pwdata[rs_pkg::ST_SMPL])
            seen_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Serial master
    // ----------------------------------------------------------------
    // Clock idles high; data moves on the falling edge and the
    // answer is taken on the rising one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= S_IDLE;
            sh_q   <= 16'h0000;
            rx_q   <= 16'h0000;
            rxw_q  <= 16'h0000;
            div_q  <= 8'h00;
            bit_q  <= 5'h00;
            sclk_q <= 1'b1;
            cs_n_q <= 1'b1;
            mosi_q <= 1'b0;
        end else begin
            div_q <= half ? 8'h00 : div_q + 8'h01;
            case (st_q)
                S_IDLE: begin
                    div_q <= 8'h00;
                    if (start) begin
                        sh_q   <= pwdata[15:0];
                        mosi_q <= pwdata[15];
                        cs_n_q <= 1'b0;
                        bit_q  <= 5'h00;
                        st_q   <= S_SETUP;
                    end
                end
                S_SETUP, S_HIGH: begin
                    if (half && bit_q == 5'(rs_pkg::FRAME_BITS)) begin
                        cs_n_q <= 1'b1;
                        rxw_q  <= rx_q;
                        st_q   <= S_IDLE;
                    end else if (half) begin
                        sclk_q <= 1'b0;
                        mosi_q <= sh_q[15];
                        sh_q   <= {sh_q[14:0], 1'b0};
                        st_q   <= S_LOW;
                    end
                end
                S_LOW: begin
                    if (half) begin
                        sclk_q <= 1'b1;
                        rx_q   <= {rx_q[14:0], miso_s_q[1]};
                        bit_q  <= bit_q + 5'h01;
                        st_q   <= S_HIGH;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign link.mosi = mosi_q;
endmodule

// [test/link_monitor.sv]
/*
 Checker for the serial pins joining host and device ends.
 Assumes a 250 MHz pclk and the shortened sample tick of the bench.
*/
`timescale 1ns/1ps
module link_monitor #(
    parameter int TICK_CYC = 8  // Device sample tick period
) (
    input wire logic pclk,        // System clock
    input wire logic presetn,     // Reset, active low
    input wire logic sclk,        // Serial clock
    input wire logic cs_n,        // Chip select
    input wire logic mosi,        // Host data
    input wire logic miso_o,      // Device data
    input wire logic miso_oe,     // Device enable
    input wire logic sample_done  // Sample pin
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    localparam int P_LO = TICK_CYC * 32 - 1;
    localparam int P_HI = TICK_CYC * 32 + 1;
    logic [7:0] low_q;
    logic [4:0] rise_q;

    // Low phase length, cleared whenever sclk is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_q <= 8'h00;
        else if (sclk) low_q <= 8'h00;
        else low_q <= low_q + 8'h01;
    end

    // Rising edges seen inside one frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rise_q <= 5'h00;
        else if (cs_n) rise_q <= 5'h00;
        else if ($rose(sclk)) rise_q <= rise_q + 5'h01;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Pulse of four cycles, then low again
    sequence s_pulse;
        sample_done [*4] ##1 !sample_done;
    endsequence

    a_oe_idle: assert property (cs_n [*4] |-> !miso_oe)
        else $error("miso driven while deselected");
    a_sclk_idle: assert property (cs_n |-> sclk)
        else $error("sclk low outside frame");
    a_half_period: assert property ($rose(sclk) && !cs_n |-> low_q == 8'h3F)
        else $error("sclk low phase length wrong");
    a_frame_bits: assert property ($rose(cs_n) |-> rise_q == 5'h10)
        else $error("frame not sixteen clocks");
    a_mosi_hold: assert property (!cs_n && !$past(cs_n) && sclk |-> $stable(mosi))
        else $error("mosi moved while sclk high");
    a_miso_hold: assert property ((miso_oe && sclk) [*4] |-> $stable(miso_o))
        else $error("miso moved while sclk high");
    a_done_width: assert property ($rose(sample_done) |-> s_pulse)
        else $error("sample pulse width wrong");
    a_done_period: assert property ($rose(sample_done) |-> ##[P_LO:P_HI] $rose(sample_done))
        else $error("sample pulse period wrong");
endmodule

// [test/tb.sv]
/*
 Bench: host and device joined by the link interface, driven over APB.
 Assumes shortened tick and backup counts on the device end.
*/
`timescale 1ns/1ps
module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        por_n = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rate_in = 32'h5DC0B7A5;
    logic [15:0] temp_in = 16'hE50F;
    logic [31:0] prdata, r;
    logic        pready, pslverr, busy, e;
    logic        seen = 1'b0;
    logic [4:0]  dec;
    logic [15:0] prd;
    int          fails = 0, comparisons = 0, cyc = 0;

    spi_link_if link ();
    rate_sensor_dev #(.TICK_CYC(8), .BACKUP_CYC(20)) u_rate_sensor_dev (.pclk(pclk),
        .presetn(presetn), .por_n(por_n), .link(link), .rate_in(rate_in), .temp_in(temp_in),
        .decimation_setting(dec), .sample_period_setting(prd), .backup_busy(busy));
    rate_sensor_host u_rate_sensor_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    link_monitor #(.TICK_CYC(8)) u_link_monitor (.pclk(pclk), .presetn(presetn),
        .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso_o(link.miso_o),
        .miso_oe(link.miso_oe), .sample_done(link.sample_done));

    // ------------------------------------------------------------
    // Clock, watchdog and access tasks
    // ------------------------------------------------------------
    always #2 pclk = ~pclk;

    // Backup has no host status bit, so software cannot see it; watch the port
    always @(posedge pclk) begin
        if (busy === 1'b1) seen <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fails++;
            end_sim();
        end
    end

    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // One APB transfer, then an idle cycle so calls never collide
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Send one frame and fetch the word shifted back during it
    task automatic frame(input logic [15:0] cmd);
        apb(1'b1, rs_pkg::H_CMD, {16'h0000, cmd});
        r = 32'h1;
        while (r[rs_pkg::ST_BUSY] !== 1'b0) apb(1'b0, rs_pkg::H_STAT, 32'h0);
        apb(1'b0, rs_pkg::H_RX, 32'h0);
    endtask

    task automatic rst;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    task end_sim;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge pclk);
        por_n <= 1'b1;
        @(posedge pclk);
        presetn <= 1'b1;
        // Restore lands at the first edge after release; look one edge later
        repeat (2) @(posedge pclk);
        cmp("period", 32'h1F, {16'h0, prd});
        cmp("miso_idle", 32'h1, {30'h0, link.miso_oe, link.miso});
        r = 32'h0;
        while (r[rs_pkg::ST_SMPL] !== 1'b1) apb(1'b0, rs_pkg::H_STAT, 32'h0);
        apb(1'b1, rs_pkg::H_STAT, 32'h2);
        apb(1'b0, rs_pkg::H_STAT, 32'h0);
        cmp("smpl_clear", 32'h0, {31'h0, r[rs_pkg::ST_SMPL]});
        frame(16'h0600);
        frame(16'h0400);
        cmp("rate_hi", 32'h5DC0, r);
        frame(16'h0200);
        cmp("rate_lo0", 32'h0, r);
        frame(16'h0000);
        cmp("temp", 32'hE50F, r);
        frame(16'hA203);
        cmp("dec", 32'h3, {27'h0, dec});
        frame(16'h0400);
        cmp("after_wr", 32'h0, r);
        frame(16'h0000);
        cmp("rate_lo3", 32'hA000, r);
        rst();
        cmp("dec_vol", 32'h0, {27'h0, dec});
        frame(16'hA203);
        frame(16'hA808);
        cmp("backup", 32'h1, {31'h0, seen});
        rst();
        cmp("dec_kept", 32'h3, {27'h0, dec});
        apb(1'b0, 8'h0C, 32'h0);
        cmp("slverr", 32'h1, {31'h0, e});
        end_sim();
    end
endmodule
